/* File: hw/msseq_pkg.sv */
// constants, encodings and state layout of the motion step sequencer
package msseq_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_MODE = 10'h190;
    localparam logic [9:0] IDX_HCFG = 10'h1E0;
    localparam logic [9:0] IDX_HVEL = 10'h1EB;
    localparam logic [9:0] IDX_HACC = 10'h1EC;
    localparam logic [9:0] IDX_HTRQ = 10'h1ED;
    localparam logic [9:0] IDX_HSHIFT = 10'h1EF;
    localparam logic [9:0] IDX_HPRE = 10'h1F0;
    localparam logic [9:0] IDX_CTRL = 10'h1F4;
    localparam logic [9:0] IDX_PTR = 10'h1F5;
    localparam logic [9:0] IDX_GOAL = 10'h1FE;
    localparam logic [9:0] IDX_DUR = 10'h23A;
    localparam logic [9:0] IDX_HSTART = 10'h258;
    localparam logic [9:0] TBL_LEN = 10'h010;
    localparam logic [9:0] HCFG_LEN = 10'h004;
    // mode codes
    localparam logic [15:0] MODE_RUN = 16'h0032;
    localparam logic [15:0] MODE_DONE = 16'h0036;
    // table control fields
    localparam int CTRL_DELAY = 0;
    localparam int CTRL_SEC = 1;
    localparam int CTRL_MIN = 2;
    localparam int CTRL_REPEAT = 3;
    // reference step fields
    localparam int CFG_SRC_LSB = 0;
    localparam int CFG_DIR = 6;
    localparam int CFG_POL = 7;
    localparam int CFG_FILT_LSB = 8;
    localparam int CFG_SPD_LSB = 12;
    localparam logic [5:0] SRC_OFF = 6'h00;
    localparam logic [5:0] SRC_TORQUE = 6'h01;
    localparam logic [5:0] SRC_IN_FIRST = 6'h02;
    localparam logic [5:0] SRC_IN_LAST = 6'h09;
    localparam logic [5:0] SRC_TIME = 6'h0A;
    localparam logic [3:0] SPD_FULL = 4'hF;
    // time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] UNIT_MS = 16'h0001;
    localparam logic [15:0] UNIT_SEC = 16'h03E8;
    localparam logic [15:0] UNIT_MIN = 16'hEA60;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_LOAD = 2'b01,
        SEQ_WAIT = 2'b10,
        SEQ_COUNT = 2'b11
    } msseq_seq_t;

    typedef enum logic [1:0] {
        HOME_IDLE = 2'b00,
        HOME_STEP = 2'b01
    } msseq_home_t;

    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] ctrl;
        logic [3:0] ptr;
        logic [15:0][31:0] goal;
        logic [15:0][15:0] dur;
        logic [3:0][15:0] hcfg;
        logic [15:0] hvel;
        logic [15:0] hacc;
        logic [15:0] htrq;
        logic [15:0] hshift;
        logic [31:0] hpre;
        logic aw_got;
        logic w_got;
        logic [9:0] widx;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        msseq_seq_t sst;
        logic [31:0] prescale;
        logic [15:0] unit_cnt;
        logic [15:0] remain;
        logic [31:0] goal_out;
        logic seq_act;
        msseq_home_t hst;
        logic [1:0] hstep;
        logic [15:0] filt_cnt;
        logic home_act;
        logic home_dir;
        logic [15:0] home_vel;
        logic pos_load;
        logic [31:0] pos_val;
    } msseq_state_t;
endpackage

/* File: hw/msseq_top.sv */
// motion step sequencer: step table and reference-finding sequencers behind an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - delay bit clear: duration count starts at once, then advances regardless of target
// - delay bit set: count held until the entry's goal is reported reached
// - time-scale bits pick milliseconds, seconds (low bit) or minutes (high bit)
// - repeat clear: a zero duration entry ends the sequence
// - repeat set: zero duration entries are skipped, sequence keeps running
// - table pointer holds only 0 to 15, the entry now processed
// - pointer increments by one per finished entry while running
// - after entry 15 the pointer wraps to 0 and continues
// - termination on zero duration writes 54 into the mode register
// - reference finding runs up to four steps in order
// - each step has its own 16-bit configuration register
// - base velocity and acceleration registers drive every reference move
// - condition source zero disables the step, which is skipped
// - source one compares motor torque against the torque limit
// - source ten runs the motor for the filter-defined time only
// - direction bit zero moves positive, one moves negative
// - polarity clear: low input or torque below; set: high or above
// - condition counts only after consecutive true regulator cycles; zero means none
// - filter N needs two to the power N consecutive cycles
// - four-bit relative speed scales 0 to 100 percent of base velocity
// - after the steps, store position minus preset and load preset in the same cycle
module msseq_top #(
    parameter int MS_CYCLES = msseq_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // motion feedback
    input wire logic reg_cycle,
    input wire logic goal_reached,
    input wire logic [15:0] motor_torque,
    input wire logic [31:0] motor_position,
    input wire logic [7:0] digital_in,
    // motion commands
    output logic seq_active,
    output logic [31:0] seq_goal,
    output logic home_active,
    output logic home_dir,
    output logic [15:0] home_velocity,
    output logic [15:0] home_accel,
    output logic pos_load,
    output logic [31:0] pos_load_value
);
    msseq_pkg::msseq_state_t s_ff;
    msseq_pkg::msseq_state_t nxt_s;
    logic mode_wr;
    logic tick_done;
    logic [15:0] cur_dur;
    logic [15:0] cfg;
    logic [5:0] src;
    logic [3:0] filt;
    logic cond;
    logic step_end;

    // ----------------------------------------
    // register read decode
    // ----------------------------------------
    function automatic logic rd_hit(input logic [9:0] idx);
        rd_hit = idx == msseq_pkg::IDX_MODE || idx == msseq_pkg::IDX_CTRL
            || idx == msseq_pkg::IDX_PTR || idx == msseq_pkg::IDX_HVEL
            || idx == msseq_pkg::IDX_HACC || idx == msseq_pkg::IDX_HTRQ
            || idx == msseq_pkg::IDX_HSHIFT || idx == msseq_pkg::IDX_HPRE
            || idx == msseq_pkg::IDX_HSTART
            || (idx >= msseq_pkg::IDX_HCFG && idx < msseq_pkg::IDX_HCFG + msseq_pkg::HCFG_LEN)
            || (idx >= msseq_pkg::IDX_GOAL && idx < msseq_pkg::IDX_GOAL + msseq_pkg::TBL_LEN)
            || (idx >= msseq_pkg::IDX_DUR && idx < msseq_pkg::IDX_DUR + msseq_pkg::TBL_LEN);
    endfunction

    function automatic logic [31:0] rd_val(input msseq_pkg::msseq_state_t s, input logic [9:0] idx);
        logic [9:0] g;
        logic [9:0] d;
        logic [9:0] h;
        g = idx - msseq_pkg::IDX_GOAL;
        d = idx - msseq_pkg::IDX_DUR;
        h = idx - msseq_pkg::IDX_HCFG;
        rd_val = 32'h0000_0000;
        if (idx == msseq_pkg::IDX_MODE)
            rd_val = {16'h0000, s.mode};
        else if (idx == msseq_pkg::IDX_CTRL)
            rd_val = {16'h0000, s.ctrl};
        else if (idx == msseq_pkg::IDX_PTR)
            rd_val = {28'h000_0000, s.ptr};
        else if (idx == msseq_pkg::IDX_HVEL)
            rd_val = {16'h0000, s.hvel};
        else if (idx == msseq_pkg::IDX_HACC)
            rd_val = {16'h0000, s.hacc};
        else if (idx == msseq_pkg::IDX_HTRQ)
            rd_val = {16'h0000, s.htrq};
        else if (idx == msseq_pkg::IDX_HSHIFT)
            rd_val = {16'h0000, s.hshift};
        else if (idx == msseq_pkg::IDX_HPRE)
            rd_val = s.hpre;
        else if (idx == msseq_pkg::IDX_HSTART)
            rd_val = {31'h0000_0000, s.home_act};
        else if (idx >= msseq_pkg::IDX_HCFG && idx < msseq_pkg::IDX_HCFG + msseq_pkg::HCFG_LEN)
            rd_val = {16'h0000, s.hcfg[h[1:0]]};
        else if (idx >= msseq_pkg::IDX_GOAL && idx < msseq_pkg::IDX_GOAL + msseq_pkg::TBL_LEN)
            rd_val = s.goal[g[3:0]];
        else if (idx >= msseq_pkg::IDX_DUR && idx < msseq_pkg::IDX_DUR + msseq_pkg::TBL_LEN)
            rd_val = {16'h0000, s.dur[d[3:0]]};
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        logic [31:0] m;
        logic [31:0] wv;
        logic [9:0] wi;
        logic [16:0] need;
        logic [15:0] unit_len;
        logic [19:0] prod;
        need = 17'h0_0000;
        unit_len = 16'h0000;
        prod = 20'h0_0000;
        m = {{8{s_ff.wstrb[3]}}, {8{s_ff.wstrb[2]}}, {8{s_ff.wstrb[1]}}, {8{s_ff.wstrb[0]}}};
        wv = (rd_val(s_ff, s_ff.widx) & ~m) | (s_ff.wdata & m);
        wi = s_ff.widx;
        nxt_s = s_ff;
        nxt_s.pos_load = 1'b0;
        mode_wr = 1'b0;
        // write channel: address and data taken in either order
        if (awvalid && s_ff.awready)
        begin
            nxt_s.aw_got = 1'b1;
            nxt_s.widx = awaddr[11:2];
        end
        if (wvalid && s_ff.wready)
        begin
            nxt_s.w_got = 1'b1;
            nxt_s.wdata = wdata;
            nxt_s.wstrb = wstrb;
        end
        if (s_ff.bvalid && bready)
            nxt_s.bvalid = 1'b0;
        if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid)
        begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = rd_hit(wi) ? msseq_pkg::RESP_OKAY : msseq_pkg::RESP_SLVERR;
            if (wi == msseq_pkg::IDX_MODE)
            begin
                nxt_s.mode = wv[15:0];
                mode_wr = 1'b1;
            end
            if (wi == msseq_pkg::IDX_CTRL)
                nxt_s.ctrl = wv[15:0];
            if (wi == msseq_pkg::IDX_PTR)
                nxt_s.ptr = wv[3:0];
            if (wi == msseq_pkg::IDX_HVEL)
                nxt_s.hvel = wv[15:0];
            if (wi == msseq_pkg::IDX_HACC)
                nxt_s.hacc = wv[15:0];
            if (wi == msseq_pkg::IDX_HTRQ)
                nxt_s.htrq = wv[15:0];
            if (wi == msseq_pkg::IDX_HPRE)
                nxt_s.hpre = wv;
            if (wi >= msseq_pkg::IDX_HCFG && wi < msseq_pkg::IDX_HCFG + msseq_pkg::HCFG_LEN)
                nxt_s.hcfg[wi[1:0]] = wv[15:0];
            if (wi >= msseq_pkg::IDX_GOAL && wi < msseq_pkg::IDX_GOAL + msseq_pkg::TBL_LEN)
                nxt_s.goal[4'(wi - msseq_pkg::IDX_GOAL)] = wv;
            if (wi >= msseq_pkg::IDX_DUR && wi < msseq_pkg::IDX_DUR + msseq_pkg::TBL_LEN)
                nxt_s.dur[4'(wi - msseq_pkg::IDX_DUR)] = wv[15:0];
            if (wi == msseq_pkg::IDX_HSTART && wv[0] && s_ff.hst == msseq_pkg::HOME_IDLE)
            begin
                nxt_s.hst = msseq_pkg::HOME_STEP;
                nxt_s.hstep = 2'h0;
                nxt_s.filt_cnt = 16'h0000;
            end
        end
        // read channel answers one cycle after the address is taken
        if (s_ff.rvalid && rready)
            nxt_s.rvalid = 1'b0;
        if (arvalid && s_ff.arready)
        begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata = rd_val(s_ff, araddr[11:2]);
            nxt_s.rresp = rd_hit(araddr[11:2]) ? msseq_pkg::RESP_OKAY : msseq_pkg::RESP_SLVERR;
        end

        // ----------------------------------------
        // step table sequencer
        // ----------------------------------------
        cur_dur = s_ff.dur[s_ff.ptr];
        if (s_ff.ctrl[msseq_pkg::CTRL_SEC])
            unit_len = msseq_pkg::UNIT_SEC;
        else if (s_ff.ctrl[msseq_pkg::CTRL_MIN])
            unit_len = msseq_pkg::UNIT_MIN;
        else
            unit_len = msseq_pkg::UNIT_MS;
        tick_done = s_ff.sst == msseq_pkg::SEQ_COUNT && s_ff.prescale == 32'(MS_CYCLES - 1)
            && s_ff.unit_cnt == unit_len - 16'h0001 && s_ff.remain == 16'h0001;
        // any mode write stops a running table; writing the run code restarts it at the pointer
        if (mode_wr)
        begin
            nxt_s.sst = nxt_s.mode == msseq_pkg::MODE_RUN ? msseq_pkg::SEQ_LOAD : msseq_pkg::SEQ_IDLE;
        end
        else
        begin
            case (s_ff.sst)
                msseq_pkg::SEQ_IDLE:
                    nxt_s.sst = msseq_pkg::SEQ_IDLE;
                msseq_pkg::SEQ_LOAD:
                begin
                    nxt_s.prescale = 32'h0000_0000;
                    nxt_s.unit_cnt = 16'h0000;
                    nxt_s.remain = cur_dur;
                    if (cur_dur == 16'h0000 && !s_ff.ctrl[msseq_pkg::CTRL_REPEAT])
                    begin
                        nxt_s.mode = msseq_pkg::MODE_DONE;
                        nxt_s.sst = msseq_pkg::SEQ_IDLE;
                    end
                    else if (cur_dur == 16'h0000)
                        nxt_s.ptr = s_ff.ptr + 4'h1;
                    else
                    begin
                        nxt_s.goal_out = s_ff.goal[s_ff.ptr];
                        nxt_s.sst = s_ff.ctrl[msseq_pkg::CTRL_DELAY]
                            ? msseq_pkg::SEQ_WAIT : msseq_pkg::SEQ_COUNT;
                    end
                end
                msseq_pkg::SEQ_WAIT:
                    if (goal_reached)
                        nxt_s.sst = msseq_pkg::SEQ_COUNT;
                msseq_pkg::SEQ_COUNT:
                begin
                    nxt_s.prescale = s_ff.prescale + 32'h0000_0001;
                    if (s_ff.prescale == 32'(MS_CYCLES - 1))
                    begin
                        nxt_s.prescale = 32'h0000_0000;
                        nxt_s.unit_cnt = s_ff.unit_cnt + 16'h0001;
                        if (s_ff.unit_cnt == unit_len - 16'h0001)
                        begin
                            nxt_s.unit_cnt = 16'h0000;
                            nxt_s.remain = s_ff.remain - 16'h0001;
                        end
                    end
                    if (tick_done)
                    begin
                        // 4-bit pointer wraps 15 to 0 by itself
                        nxt_s.ptr = s_ff.ptr + 4'h1;
                        nxt_s.sst = msseq_pkg::SEQ_LOAD;
                    end
                end
                default:
                    nxt_s.sst = msseq_pkg::SEQ_IDLE;
            endcase
        end

        // ----------------------------------------
        // reference-finding sequencer
        // ----------------------------------------
        cfg = s_ff.hcfg[s_ff.hstep];
        src = cfg[msseq_pkg::CFG_SRC_LSB +: 6];
        filt = cfg[msseq_pkg::CFG_FILT_LSB +: 4];
        need = 17'h0_0001 << filt;
        if (src == msseq_pkg::SRC_TORQUE)
            cond = cfg[msseq_pkg::CFG_POL] ? $signed(motor_torque) > $signed(s_ff.htrq)
                : $signed(motor_torque) < $signed(s_ff.htrq);
        else if (src >= msseq_pkg::SRC_IN_FIRST && src <= msseq_pkg::SRC_IN_LAST)
            cond = digital_in[3'(src - msseq_pkg::SRC_IN_FIRST)] == cfg[msseq_pkg::CFG_POL];
        else
            cond = src == msseq_pkg::SRC_TIME;
        step_end = reg_cycle && cond && {1'b0, s_ff.filt_cnt} + 17'h0_0001 >= need;
        prod = s_ff.hvel[15:4] * cfg[msseq_pkg::CFG_SPD_LSB +: 4];
        nxt_s.home_dir = cfg[msseq_pkg::CFG_DIR];
        // divide before multiply keeps the product narrow at the cost of 4 lsb of resolution
        nxt_s.home_vel = cfg[msseq_pkg::CFG_SPD_LSB +: 4] == msseq_pkg::SPD_FULL ? s_ff.hvel
            : {12'(prod / 20'(msseq_pkg::SPD_FULL)), 4'h0};
        if (s_ff.hst == msseq_pkg::HOME_STEP)
        begin
            if (src == msseq_pkg::SRC_OFF || src > msseq_pkg::SRC_TIME || step_end)
            begin
                nxt_s.filt_cnt = 16'h0000;
                nxt_s.hstep = s_ff.hstep + 2'h1;
                if (s_ff.hstep == 2'h3)
                begin
                    nxt_s.hst = msseq_pkg::HOME_IDLE;
                    nxt_s.hshift = 16'(motor_position - s_ff.hpre);
                    nxt_s.pos_load = 1'b1;
                    nxt_s.pos_val = s_ff.hpre;
                end
            end
            else if (reg_cycle)
                nxt_s.filt_cnt = cond ? s_ff.filt_cnt + 16'h0001 : 16'h0000;
        end
        nxt_s.seq_act = nxt_s.sst != msseq_pkg::SEQ_IDLE;
        nxt_s.home_act = nxt_s.hst == msseq_pkg::HOME_STEP;
        nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
        nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;
        nxt_s.arready = !nxt_s.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign awready = s_ff.awready;
    assign wready = s_ff.wready;
    assign bvalid = s_ff.bvalid;
    assign bresp = s_ff.bresp;
    assign arready = s_ff.arready;
    assign rvalid = s_ff.rvalid;
    assign rdata = s_ff.rdata;
    assign rresp = s_ff.rresp;
    assign seq_active = s_ff.seq_act;
    assign seq_goal = s_ff.goal_out;
    assign home_active = s_ff.home_act;
    assign home_dir = s_ff.home_dir;
    assign home_velocity = s_ff.home_vel;
    assign home_accel = s_ff.hacc;
    assign pos_load = s_ff.pos_load;
    assign pos_load_value = s_ff.pos_val;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    seq_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ff.sst == msseq_pkg::SEQ_LOAD && cur_dur == 16'h0000 && !s_ff.ctrl[3] && !mode_wr
        |=> s_ff.mode == 16'h0036 ##1 !seq_active) else $error("zero duration did not finish");
    zero_skip_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ff.sst == msseq_pkg::SEQ_LOAD && cur_dur == 16'h0000 && s_ff.ctrl[3] && !mode_wr
        |=> s_ff.ptr == $past(s_ff.ptr) + 4'h1 && s_ff.sst == msseq_pkg::SEQ_LOAD)
        else $error("zero duration not skipped");
    delay_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ff.sst == msseq_pkg::SEQ_WAIT && !goal_reached && !mode_wr
        |=> s_ff.sst == msseq_pkg::SEQ_WAIT && $stable(s_ff.remain)) else $error("count ran before goal");
    no_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ff.sst == msseq_pkg::SEQ_LOAD && cur_dur != 16'h0000 && !s_ff.ctrl[0] && !mode_wr
        |=> s_ff.sst == msseq_pkg::SEQ_COUNT && s_ff.remain == $past(cur_dur))
        else $error("count did not start at once");
    ptr_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tick_done && !mode_wr |=> s_ff.ptr == $past(s_ff.ptr) + 4'h1 ##1 seq_goal == s_ff.goal[$past(s_ff.ptr, 2) + 4'h1]
        || s_ff.sst != msseq_pkg::SEQ_COUNT) else $error("pointer not advanced");
    step_skip_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ff.hst == msseq_pkg::HOME_STEP && src == 6'h00 |=> s_ff.hstep == $past(s_ff.hstep) + 2'h1)
        else $error("disabled step not skipped");
    home_finish_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ff.hst == msseq_pkg::HOME_STEP && s_ff.hstep == 2'h3 && (src == 6'h00 || step_end)
        |=> pos_load && pos_load_value == $past(s_ff.hpre) ##1 !pos_load) else $error("preset not loaded");
    no_filter_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_ff.hst == msseq_pkg::HOME_STEP && filt == 4'h0 && src == 6'h02 && reg_cycle && cond
        |=> s_ff.hstep != $past(s_ff.hstep) || !home_active) else $error("unfiltered step did not end");
endmodule
`default_nettype wire

/* File: dv/msseq_host.sv */
// host master model: register accesses over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module msseq_host (
    // clock
    input wire logic aclk,
    // write side
    output logic [11:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    // read side
    output logic [11:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial
    begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hF;
    end
    // extra edge at the end so a following call never drives a signal twice in one step
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        awaddr <= {idx, 2'h0};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule
`default_nettype wire

/* File: dv/test_motion_step_sequencer.sv */
// self-checking bench of the motion step sequencer
`timescale 1ns/100ps
`default_nettype none
module test_motion_step_sequencer;
    logic aclk = 1'b0, aresetn = 1'b0, reg_cycle = 1'b0, goal_reached = 1'b0;
    logic [31:0] motor_position = 32'h0000_0100;
    logic [15:0] motor_torque = 16'h0000;
    logic [7:0] digital_in = 8'h00;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seq_goal, pos_load_value, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic seq_active, home_active, home_dir, pos_load;
    logic [15:0] home_velocity, home_accel;
    int errors = 0, tests_run = 0;
    // pos_load stands one cycle only, so latch it for the sequence to look at later
    logic seen_load = 1'b0;
    logic [31:0] load_val = 32'h0000_0000;
    always #12.5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        if (pos_load === 1'b1)
        begin
            seen_load <= 1'b1;
            load_val <= pos_load_value;
        end
    end
    msseq_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // short millisecond keeps millisecond entries within a few cycles and a one-second entry at 4000
    msseq_top #(.MS_CYCLES(4)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .reg_cycle(reg_cycle),
        .goal_reached(goal_reached), .motor_torque(motor_torque), .motor_position(motor_position),
        .digital_in(digital_in), .seq_active(seq_active), .seq_goal(seq_goal), .home_active(home_active),
        .home_dir(home_dir), .home_velocity(home_velocity), .home_accel(home_accel), .pos_load(pos_load),
        .pos_load_value(pos_load_value));
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic pulse;
        @(posedge aclk);
        reg_cycle <= 1'b1;
        @(posedge aclk);
        reg_cycle <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    task automatic run(input logic [3:0] p, input logic [15:0] c, input int hold, input logic [3:0] endp);
        i_host.wr(msseq_pkg::IDX_PTR, {28'h0, p});
        i_host.wr(msseq_pkg::IDX_CTRL, {16'h0, c});
        i_host.wr(msseq_pkg::IDX_MODE, {16'h0, msseq_pkg::MODE_RUN});
        if (hold > 0)
        begin
            repeat (hold) @(posedge aclk);
            i_host.rd(msseq_pkg::IDX_PTR, d, r);
            check("held pointer", d, {28'h0, p});
            goal_reached <= 1'b1;
        end
        d = '0;
        while (d[15:0] !== msseq_pkg::MODE_DONE)
            i_host.rd(msseq_pkg::IDX_MODE, d, r);
        i_host.rd(msseq_pkg::IDX_PTR, d, r);
        check("end pointer", d, {28'h0, endp});
        check("table idle", {31'h0, seq_active}, 32'h0);
    endtask
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        i_host.rd(msseq_pkg::IDX_PTR, d, r);
        check("reset pointer", d, 32'h0);
        i_host.rd(10'h3FF, d, r);
        check("unmapped resp", {30'h0, r}, {30'h0, msseq_pkg::RESP_SLVERR});
        i_host.wr(msseq_pkg::IDX_GOAL + 10'h00F, 32'h0BAD_F00D);
        i_host.wr(msseq_pkg::IDX_DUR, 32'h2);
        i_host.wr(msseq_pkg::IDX_DUR + 10'h00F, 32'h1);
        run(4'h0, 16'h0000, 0, 4'h1);
        i_host.wr(msseq_pkg::IDX_DUR, 32'h0);
        run(4'hF, 16'h0001, 40, 4'h0);
        run(4'hF, 16'h0002, 3000, 4'h0);
        // repeat: only entry 15 is timed, every zero entry is passed over
        i_host.wr(msseq_pkg::IDX_CTRL, 32'h8);
        i_host.wr(msseq_pkg::IDX_MODE, {16'h0, msseq_pkg::MODE_RUN});
        repeat (80) @(posedge aclk);
        check("repeat goal", seq_goal, 32'h0BAD_F00D);
        i_host.rd(msseq_pkg::IDX_MODE, d, r);
        check("repeat mode", d, {16'h0, msseq_pkg::MODE_RUN});
        i_host.wr(msseq_pkg::IDX_MODE, 32'h0);
        check("stopped", {31'h0, seq_active}, 32'h0);
        // reference: input one high, filter 2 pulses, then a timed step, then torque above the limit, last step off
        i_host.wr(msseq_pkg::IDX_HCFG, 32'hF1C2);
        i_host.wr(msseq_pkg::IDX_HCFG + 10'h001, 32'h000A);
        i_host.wr(msseq_pkg::IDX_HCFG + 10'h002, 32'h0081);
        i_host.wr(msseq_pkg::IDX_HVEL, 32'h1000);
        i_host.wr(msseq_pkg::IDX_HACC, 32'h0200);
        i_host.wr(msseq_pkg::IDX_HPRE, 32'h10);
        i_host.wr(msseq_pkg::IDX_HSTART, 32'h1);
        check("home run", {31'h0, home_active}, 32'h1);
        check("home dir", {31'h0, home_dir}, 32'h1);
        check("home vel", {16'h0, home_velocity}, 32'h1000);
        check("home acc", {16'h0, home_accel}, 32'h0200);
        digital_in <= 8'h01;
        pulse();
        check("filtered", {31'h0, home_dir}, 32'h1);
        pulse();
        check("step two dir", {31'h0, home_dir}, 32'h0);
        check("step two vel", {16'h0, home_velocity}, 32'h0);
        pulse();
        check("torque wait", {31'h0, home_active}, 32'h1);
        motor_torque <= 16'h0005;
        pulse();
        while (seen_load !== 1'b1)
            @(posedge aclk);
        check("preset", load_val, 32'h10);
        i_host.rd(msseq_pkg::IDX_HSHIFT, d, r);
        check("shift", {16'h0, d[15:0]}, 32'h00F0);
        check("home done", {31'h0, home_active}, 32'h0);
        print_verdict();
    end
    initial
    begin
        #500000;
        errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
